// *** design/gcrb_frame_if.sv ***
// decoded serial frame passed from the frame engine to the register bank
`timescale 1ns/10ps
interface gcrb_frame_if;
   logic frame_done;
   logic wr;
   logic [4:0] addr;
   gcrb_pkg::gcrb_word_t wdata;
   gcrb_pkg::gcrb_word_t rdata;

   modport engine (
      output frame_done,
      output wr,
      output addr,
      output wdata,
      input rdata
   );
   modport bank (
      input frame_done,
      input wr,
      input addr,
      input wdata,
      output rdata
   );
endinterface

// *** design/gcrb_pkg.sv ***
// types shared by the control bank modules
package gcrb_pkg;
   typedef logic [15:0] gcrb_word_t;
   typedef logic [2:0][15:0] gcrb_dly_arr_t;
   typedef enum logic [1:0] {WD_OFF, WD_RUN, WD_EXPIRED} gcrb_wd_state_t;
endpackage

// *** design/gcrb_regs.svh ***
// offsets, field positions, reset values and timing of the control bank
`ifndef GCRB_REGS_SVH
`define GCRB_REGS_SVH

`define GCRB_ADDR_W 5
`define GCRB_DATA_W 16
`define GCRB_OFS_GC1 5'h00
`define GCRB_OFS_GC2 5'h01
`define GCRB_OFS_DLY1 5'h0e
`define GCRB_NUM_DLY 3

`define GCRB_GC1_RESET 16'h0026
`define GCRB_GC1_RW_MASK 16'hffaf
`define GCRB_DLY_RESET 16'h0a0a
`define GCRB_WATCHDOG_DISABLE_RESET 1'b0

`define GCRB_B_S2DIR 15
`define GCRB_B_S2GAIN_HI 14
`define GCRB_B_S2GAIN_LO 13
`define GCRB_B_S1DIR 12
`define GCRB_B_S1GAIN_HI 11
`define GCRB_B_S1GAIN_LO 10
`define GCRB_B_BANK 9
`define GCRB_B_OVTH 8
`define GCRB_B_UNLOCK 7
`define GCRB_B_FM 5
`define GCRB_B_STEP 3
`define GCRB_B_OVERCURRENT_SHUTDOWN_ENABLE 2
`define GCRB_B_WATCHDOG_PERIOD_SELECT 1
`define GCRB_B_TRIG 0
`define GCRB_B_WATCHDOG_DISABLE 9

`define GCRB_FRAME_BITS 5'd24
`define GCRB_HDR_LAST 5'd7
`define GCRB_CUR_W 5

`define GCRB_CLK_MHZ 200
`define GCRB_WD_SHORT_MS 50
`define GCRB_WD_LONG_MS 200
`define GCRB_WD_CNT_W 26

`endif

// *** design/gcrb_spi_frame.sv ***
// 24-bit serial frame engine, pins sampled on the system clock
`timescale 1ns/10ps
`include "gcrb_regs.svh"
module gcrb_spi_frame (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic csn_n_i,
   input wire logic sclk_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   gcrb_frame_if.engine fr
);
   logic sclk_q;
   logic csn_q;
   logic rise;
   logic fall;
   logic load_q;
   logic [4:0] bit_cnt;
   logic [23:0] in_sh;
   logic [15:0] out_sh;
   logic wr_reg;
   logic [4:0] addr_reg;

   assign rise = sclk_i & ~sclk_q & ~csn_n_i;
   assign fall = ~sclk_i & sclk_q & ~csn_n_i;

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         sclk_q <= 1'b0;
         csn_q <= 1'b1;
      end
      else
      begin
         sclk_q <= sclk_i;
         csn_q <= csn_n_i;
      end
   end

   // count saturates so long frames are never committed
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i || csn_n_i)
         bit_cnt <= 5'd0;
      else if (rise && bit_cnt != 5'h1f)
         bit_cnt <= bit_cnt + 5'd1;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         in_sh <= 24'h000000;
      else if (rise)
         in_sh <= {in_sh[22:0], sdi_i};
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         wr_reg <= 1'b0;
         addr_reg <= 5'h00;
      end
      else if (rise && bit_cnt == `GCRB_HDR_LAST)
      begin
         wr_reg <= in_sh[6];
         addr_reg <= {in_sh[3:0], sdi_i};
      end
   end

   // read word is fetched one cycle after the header is complete
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         load_q <= 1'b0;
      else
         load_q <= rise && bit_cnt == `GCRB_HDR_LAST;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i || csn_n_i)
      begin
         out_sh <= 16'h0000;
         sdo_o <= 1'b0;
      end
      else if (load_q)
         out_sh <= fr.rdata;
      else if (fall)
      begin
         sdo_o <= out_sh[15];
         out_sh <= {out_sh[14:0], 1'b0};
      end
   end

   assign sdo_oe_o = ~csn_n_i;
   assign fr.frame_done = csn_n_i & ~csn_q & (bit_cnt == `GCRB_FRAME_BITS);
   assign fr.wr = wr_reg;
   assign fr.addr = addr_reg;
   assign fr.wdata = in_sh[15:0];
endmodule

// *** design/gcrb_top.sv ***
// general control register bank with serial access and watchdog
`timescale 1ns/10ps
`include "gcrb_regs.svh"

////////////////////////////////////////////////////////////////////////////
// What this block does
// - bit 15: sense two direction, 0 unidirectional, 1 bidirectional.
// - bits 14:13: sense two gain 10/20/40/80 V/V, reset 00.
// - bit 12: sense one direction, 0 unidirectional, 1 bidirectional.
// - bits 11:10: sense one gain 10/20/40/80 V/V, reset 00.
// - bit 9: bank select for shared offsets, reset active set.
// - bit 8: supply overvoltage threshold low when 0, high when 1.
// - unlock bit 7 allows watchdog disable set next frame only.
// - bit 6 reads zero and ignores writes.
// - bit 5: frequency modulation, on after reset.
// - bit 3: adaptation step one or two current steps.
// - bit 2: overcurrent shutdown enable, on after reset.
// - bit 1: watchdog period 50 ms or 200 ms, reset 200 ms.
// - write leaving trigger bit unchanged puts device in fail-safe.
// - three delay registers at 0x0e..0x10, both banks, reset 0x0a0a.
// - max pre-charge current also drives post-discharge phase.
// - watchdog disable sets only after unlock frame; clear is immediate.
module gcrb_top #(
   parameter int unsigned WD_SHORT_CYC =
      `GCRB_WD_SHORT_MS * 1000 * `GCRB_CLK_MHZ,
   parameter int unsigned WD_LONG_CYC =
      `GCRB_WD_LONG_MS * 1000 * `GCRB_CLK_MHZ
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic csn_n_i,
   input wire logic sclk_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   input wire logic post_discharge_i,
   input wire logic [`GCRB_CUR_W-1:0] precharge_current_i,
   input wire logic [`GCRB_CUR_W-1:0] max_precharge_current_i,
   output logic [`GCRB_CUR_W-1:0] active_gate_current_o,
   output logic sense_two_direction_o,
   output logic [1:0] sense_two_gain_o,
   output logic sense_one_direction_o,
   output logic [1:0] sense_one_gain_o,
   output logic bank_select_o,
   output logic supply_overvoltage_threshold_select_o,
   output logic frequency_modulation_enable_o,
   output logic adaptation_step_size_o,
   output logic overcurrent_shutdown_enable_o,
   output logic watchdog_period_select_o,
   output logic watchdog_enable_o,
   output logic fail_safe_o,
   output gcrb_pkg::gcrb_dly_arr_t pwm_channel_delays_o
);

   ////////////////////////////////////////////////////////////////////////
   // frame engine

   gcrb_frame_if fr ();

   gcrb_spi_frame u_frame (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .csn_n_i(csn_n_i),
      .sclk_i(sclk_i),
      .sdi_i(sdi_i),
      .sdo_o(sdo_o),
      .sdo_oe_o(sdo_oe_o),
      .fr(fr.engine)
   );

   ////////////////////////////////////////////////////////////////////////
   // write decode

   gcrb_pkg::gcrb_word_t general_control_one_reg;
   gcrb_pkg::gcrb_word_t general_control_one_next;
   gcrb_pkg::gcrb_dly_arr_t dly_reg;
   logic watchdog_disable_reg;
   logic unlock_armed_reg;
   logic fail_safe_reg;
   logic wd_expired;
   logic wr_gc1;
   logic wr_gc2;
   logic [`GCRB_NUM_DLY-1:0] wr_dly;
   logic trig_ok;
   logic trig_bad;
   logic kick;

   always_comb
   begin
      wr_gc1 = 1'b0;
      wr_gc2 = 1'b0;
      if (fr.frame_done && fr.wr)
      begin
         if (fr.addr == `GCRB_OFS_GC1)
            wr_gc1 = 1'b1;
         else if (fr.addr == `GCRB_OFS_GC2)
            wr_gc2 = 1'b1;
      end
   end

   // the delay registers ignore the bank bit
   genvar gi;
   generate
      for (gi = 0; gi < `GCRB_NUM_DLY; gi++)
      begin : g_dly
         assign wr_dly[gi] = fr.frame_done && fr.wr &&
            fr.addr == 5'(`GCRB_OFS_DLY1 + gi);

         always_ff @(posedge clk_i)
         begin
            if (!rst_n_i)
               dly_reg[gi] <= `GCRB_DLY_RESET;
            else if (wr_dly[gi])
               dly_reg[gi] <= fr.wdata;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // general control one

   // trigger must flip on every write to this register
   assign trig_ok = fr.wdata[`GCRB_B_TRIG] !=
      general_control_one_reg[`GCRB_B_TRIG];
   assign trig_bad = wr_gc1 && !trig_ok;
   assign kick = wr_gc1 && trig_ok;

   // reserved bits are masked so they can never be stored
   assign general_control_one_next =
      fr.wdata & `GCRB_GC1_RW_MASK;

   // a bad-trigger write is still stored, the fail-safe flag records it
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         general_control_one_reg <= `GCRB_GC1_RESET;
      else if (wr_gc1)
         general_control_one_reg <= general_control_one_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // watchdog disable and unlock handshake

   // armed only for the single frame that follows an unlock write
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         unlock_armed_reg <= 1'b0;
      else if (fr.frame_done)
         unlock_armed_reg <= wr_gc1 &&
            fr.wdata[`GCRB_B_UNLOCK];
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         watchdog_disable_reg <= `GCRB_WATCHDOG_DISABLE_RESET;
      else if (wr_gc2)
      begin
         if (!fr.wdata[`GCRB_B_WATCHDOG_DISABLE])
            watchdog_disable_reg <= 1'b0;
         else if (unlock_armed_reg)
            watchdog_disable_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // watchdog timer and fail-safe

   gcrb_watchdog #(
      .SHORT_CYC(WD_SHORT_CYC),
      .LONG_CYC(WD_LONG_CYC)
   ) u_wd (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .enable_i(!watchdog_disable_reg),
      .long_i(general_control_one_reg[`GCRB_B_WATCHDOG_PERIOD_SELECT]),
      .kick_i(kick),
      .expired_o(wd_expired)
   );

   // sticky: only a reset leaves fail-safe
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         fail_safe_reg <= 1'b0;
      else if (trig_bad || wd_expired)
         fail_safe_reg <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux, sampled by the engine after the header

   always_comb
   begin
      fr.rdata = 16'h0000;
      if (fr.addr == `GCRB_OFS_GC1)
         fr.rdata = general_control_one_reg;
      else if (fr.addr == `GCRB_OFS_GC2)
         fr.rdata[`GCRB_B_WATCHDOG_DISABLE] = watchdog_disable_reg;
      else if (fr.addr == `GCRB_OFS_DLY1)
         fr.rdata = dly_reg[0];
      else if (fr.addr == 5'(`GCRB_OFS_DLY1 + 5'd1))
         fr.rdata = dly_reg[1];
      else if (fr.addr == 5'(`GCRB_OFS_DLY1 + 5'd2))
         fr.rdata = dly_reg[2];
   end

   ////////////////////////////////////////////////////////////////////////
   // gate current steering

   // post-discharge reuses the max pre-charge setting, no separate field
   assign active_gate_current_o = post_discharge_i
      ? max_precharge_current_i
      : precharge_current_i;

   ////////////////////////////////////////////////////////////////////////
   // field outputs

   assign sense_two_direction_o =
      general_control_one_reg[`GCRB_B_S2DIR];
   assign sense_two_gain_o = general_control_one_reg[
      `GCRB_B_S2GAIN_HI:`GCRB_B_S2GAIN_LO];
   assign sense_one_direction_o =
      general_control_one_reg[`GCRB_B_S1DIR];
   assign sense_one_gain_o = general_control_one_reg[
      `GCRB_B_S1GAIN_HI:`GCRB_B_S1GAIN_LO];
   assign bank_select_o =
      general_control_one_reg[`GCRB_B_BANK];
   assign supply_overvoltage_threshold_select_o =
      general_control_one_reg[`GCRB_B_OVTH];
   assign frequency_modulation_enable_o =
      general_control_one_reg[`GCRB_B_FM];
   assign adaptation_step_size_o =
      general_control_one_reg[`GCRB_B_STEP];
   assign overcurrent_shutdown_enable_o =
      general_control_one_reg[`GCRB_B_OVERCURRENT_SHUTDOWN_ENABLE];
   assign watchdog_period_select_o =
      general_control_one_reg[`GCRB_B_WATCHDOG_PERIOD_SELECT];
   assign watchdog_enable_o = !watchdog_disable_reg;
   assign fail_safe_o = fail_safe_reg;
   assign pwm_channel_delays_o = dly_reg;

endmodule

// *** design/gcrb_watchdog.sv ***
// timeout watchdog restarted by every valid trigger toggle
`timescale 1ns/10ps
`include "gcrb_regs.svh"
module gcrb_watchdog #(
   parameter int unsigned SHORT_CYC = 1000,
   parameter int unsigned LONG_CYC = 4000
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic enable_i,
   input wire logic long_i,
   input wire logic kick_i,
   output logic expired_o
);
   gcrb_pkg::gcrb_wd_state_t state_reg;
   logic [`GCRB_WD_CNT_W-1:0] cnt_reg;
   logic [`GCRB_WD_CNT_W-1:0] limit;

   assign limit = long_i ? `GCRB_WD_CNT_W'(LONG_CYC - 1)
                         : `GCRB_WD_CNT_W'(SHORT_CYC - 1);

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= gcrb_pkg::WD_RUN;
         cnt_reg <= '0;
      end
      else
      begin
         case (state_reg)
            gcrb_pkg::WD_OFF:
               if (enable_i)
               begin
                  state_reg <= gcrb_pkg::WD_RUN;
                  cnt_reg <= '0;
               end
            gcrb_pkg::WD_RUN:
               if (!enable_i)
                  state_reg <= gcrb_pkg::WD_OFF;
               else if (kick_i)
                  cnt_reg <= '0;
               else if (cnt_reg >= limit)
                  state_reg <= gcrb_pkg::WD_EXPIRED;
               else
                  cnt_reg <= cnt_reg + 1'b1;
            default:
               if (!enable_i)
                  state_reg <= gcrb_pkg::WD_OFF;
               else if (kick_i)
               begin
                  state_reg <= gcrb_pkg::WD_RUN;
                  cnt_reg <= '0;
               end
         endcase
      end
   end

   assign expired_o = state_reg == gcrb_pkg::WD_EXPIRED;
endmodule

// *** dv/gcrb_host_model.sv ***
// serial host model sending 24-bit frames, sclk idle low
`timescale 1ns/10ps
module gcrb_host_model (
   input wire logic clk_i,
   input wire logic sdo_i,
   input wire logic sdo_oe_i,
   output logic csn_n_o,
   output logic sclk_o,
   output logic sdi_o
);
   initial
   begin
      csn_n_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
   end

   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // a length other than 24 gives a frame the bank must drop
   task automatic xfer(input logic [23:0] frm, input int nbits,
      output logic [15:0] rd);
      rd = 16'h0000;
      wait_n(1);
      csn_n_o = 1'b0;
      for (int k = 0; k < nbits; k++)
      begin
         sdi_o = frm[23-k];
         wait_n(2);
         if (k >= 8)
            rd[23-k] = sdo_oe_i ? sdo_i : 1'bx;
         sclk_o = 1'b1;
         wait_n(2);
         sclk_o = 1'b0;
      end
      wait_n(2);
      csn_n_o = 1'b1;
      // released line must not keep its last value
      sdi_o = ~sdi_o;
      wait_n(4);
   endtask
endmodule

// *** dv/gcrb_top_sva.sv ***
// concurrent checks on the pins of the control register bank
`timescale 1ns/10ps
module gcrb_top_sva #(
   parameter int unsigned WD_SHORT_CYC = 200,
   parameter int unsigned WD_LONG_CYC = 800
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic csn_n_i,
   input wire logic post_discharge_i,
   input wire logic [4:0] precharge_current_i,
   input wire logic [4:0] max_precharge_current_i,
   input wire logic [4:0] active_gate_current_o,
   input wire logic sense_two_direction_o,
   input wire logic [1:0] sense_two_gain_o,
   input wire logic sense_one_direction_o,
   input wire logic [1:0] sense_one_gain_o,
   input wire logic bank_select_o,
   input wire logic supply_overvoltage_threshold_select_o,
   input wire logic frequency_modulation_enable_o,
   input wire logic adaptation_step_size_o,
   input wire logic overcurrent_shutdown_enable_o,
   input wire logic watchdog_period_select_o,
   input wire logic watchdog_enable_o,
   input wire logic fail_safe_o,
   input gcrb_pkg::gcrb_dly_arr_t pwm_channel_delays_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [3:0] cs_q;
   logic [31:0] idle_q;
   logic wden_q;
   // commit lands a few edges after chip select rises
   wire recent = |({cs_q[2:0], csn_n_i} & ~cs_q);
   wire [11:0] fld = {sense_two_direction_o, sense_two_gain_o,
      sense_one_direction_o, sense_one_gain_o, bank_select_o,
      supply_overvoltage_threshold_select_o,
      frequency_modulation_enable_o, adaptation_step_size_o,
      overcurrent_shutdown_enable_o, watchdog_period_select_o};

   // idle count only undercounts the real one, so no false alarms
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         cs_q <= 4'hf;
         idle_q <= 32'h0;
         wden_q <= 1'b1;
      end
      else
      begin
         cs_q <= {cs_q[2:0], csn_n_i};
         wden_q <= watchdog_enable_o;
         if (recent || wden_q != watchdog_enable_o)
            idle_q <= 32'h0;
         else
            idle_q <= idle_q + 32'h1;
      end
   end

   sequence s_wd_off;
      $rose(csn_n_i) ##[1:4] $fell(watchdog_enable_o);
   endsequence

   chk_cur_mux: assert property (active_gate_current_o ==
      (post_discharge_i ? max_precharge_current_i : precharge_current_i))
      else $error("gate current mux wrong");
   chk_reset_vals: assert property (disable iff (1'b0)
      !rst_n_i |=> fld == 12'h00b && watchdog_enable_o && !fail_safe_o
      && pwm_channel_delays_o == {3{16'h0a0a}})
      else $error("reset values wrong");
   chk_fields_quiet: assert property ($changed(fld) |-> recent)
      else $error("field moved outside a frame");
   chk_dly_quiet: assert property (
      $changed(pwm_channel_delays_o) |-> recent)
      else $error("delay moved outside a frame");
   chk_wdoff_frame: assert property (
      $fell(watchdog_enable_o) |-> recent)
      else $error("watchdog disabled outside a frame");
   chk_fs_sticky: assert property (fail_safe_o |=> fail_safe_o)
      else $error("fail safe cleared");
   chk_wd_short: assert property (watchdog_enable_o &&
      !watchdog_period_select_o && idle_q > WD_SHORT_CYC + 8 |-> fail_safe_o)
      else $error("short watchdog did not expire");
   chk_wd_long: assert property (watchdog_enable_o &&
      idle_q > WD_LONG_CYC + 8 |-> fail_safe_o)
      else $error("long watchdog did not expire");
   cov_wd_off: cover property (s_wd_off);
endmodule
//////////////////////////////
bind gcrb_top gcrb_top_sva #(.WD_SHORT_CYC(WD_SHORT_CYC),
   .WD_LONG_CYC(WD_LONG_CYC)) u_sva (.*);

// *** dv/tb_general_control_register_bank.sv ***
// self-checking bench for the general control register bank
`timescale 1ns/10ps
module tb_general_control_register_bank;
   localparam int unsigned SHORT = 2000;
   localparam int unsigned LONG = 4000;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic csn_n_i, sclk_i, sdi_i, sdo_o, sdo_oe_o, trig;
   logic pd = 1'b0;
   logic [4:0] cur = 5'h00;
   logic [4:0] cmax = 5'h00;
   logic [4:0] gate;
   logic s2d, s1d, bank, ovth, fm, step, overcurrent_shutdown_enable, watchdog_period_select, wden, fs;
   logic [1:0] s2g, s1g;
   logic [15:0] rd;
   gcrb_pkg::gcrb_dly_arr_t dly;
   int fails = 0;
   int tests_run = 0;

   always #2.5 clk_i = ~clk_i;

   gcrb_top #(.WD_SHORT_CYC(SHORT), .WD_LONG_CYC(LONG)) DUT (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .csn_n_i(csn_n_i),
      .sclk_i(sclk_i), .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
      .post_discharge_i(pd), .precharge_current_i(cur),
      .max_precharge_current_i(cmax), .active_gate_current_o(gate),
      .sense_two_direction_o(s2d), .sense_two_gain_o(s2g),
      .sense_one_direction_o(s1d), .sense_one_gain_o(s1g),
      .bank_select_o(bank), .supply_overvoltage_threshold_select_o(ovth),
      .frequency_modulation_enable_o(fm), .adaptation_step_size_o(step),
      .overcurrent_shutdown_enable_o(overcurrent_shutdown_enable),
      .watchdog_period_select_o(watchdog_period_select), .watchdog_enable_o(wden),
      .fail_safe_o(fs), .pwm_channel_delays_o(dly));

   gcrb_host_model host (.clk_i(clk_i), .sdo_i(sdo_o),
      .sdo_oe_i(sdo_oe_o), .csn_n_o(csn_n_i), .sclk_o(sclk_i),
      .sdi_o(sdi_i));
   //////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
      host.xfer({3'b000, a, 16'h0000}, 24, d);
   endtask

   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] x;
      host.xfer({3'b100, a, d}, 24, x);
   endtask

   task automatic wr_gc1(input logic [15:0] d);
      trig = ~trig;
      wr_reg(5'h00, {d[15:1], trig});
   endtask

   task automatic do_reset;
      rst_n_i = 1'b0;
      repeat (12) @(negedge clk_i);
      rst_n_i = 1'b1;
      trig = 1'b0;
   endtask

   task automatic t_reset;
      rd_reg(5'h00, rd);
      chk(rd, 16'h0026);
      for (int i = 0; i < 3; i++)
      begin
         rd_reg(5'h0e + i[4:0], rd);
         chk(rd, 16'h0a0a);
      end
      rd_reg(5'h1f, rd);
      chk(rd, 16'h0000);
      chk({s2d, s2g, s1d, s1g, bank, ovth, fm, step, overcurrent_shutdown_enable, watchdog_period_select, wden,
         fs}, 16'h002e);
      $display("test reset done");
   endtask

   task automatic t_fields;
      logic [15:0] pat [4] = '{16'hffff, 16'h0000, 16'haa5a, 16'h55a5};
      logic [15:0] exp;
      for (int i = 0; i < 4; i++)
      begin
         wr_gc1(pat[i]);
         exp = {pat[i][15:1], trig} & 16'hffaf;
         rd_reg(5'h00, rd);
         chk(rd, exp);
         chk({s2d, s2g, s1d, s1g, bank, ovth}, exp[15:8]);
         chk({fm, step, overcurrent_shutdown_enable, watchdog_period_select}, {exp[5], exp[3:1]});
      end
      // short frame must be dropped
      host.xfer({3'b100, 5'h00, 16'hffff}, 16, rd);
      chk({s2d, s2g, fm}, 4'h5);
      $display("test fields done");
   endtask

   task automatic t_dly;
      for (int b = 0; b < 2; b++)
      begin
         wr_gc1({6'h00, b[0], 9'h026});
         for (int i = 0; i < 3; i++)
            wr_reg(5'h0e + i[4:0], {b[3:0], i[3:0], 8'h5c});
         for (int i = 0; i < 3; i++)
         begin
            rd_reg(5'h0e + i[4:0], rd);
            chk(rd, {b[3:0], i[3:0], 8'h5c});
            chk(dly[i], {b[3:0], i[3:0], 8'h5c});
         end
      end
      $display("test delays done");
   endtask

   task automatic t_cur;
      for (int i = 0; i < 4; i++)
      begin
         @(negedge clk_i);
         pd = i[0];
         cur = 5'h00 + i[4:0];
         cmax = 5'h1f - i[4:0];
         @(negedge clk_i);
         chk(gate, i[0] ? 5'h1f - i[4:0] : i[4:0]);
      end
      $display("test current done");
   endtask

   task automatic t_unlock;
      wr_reg(5'h01, 16'h0200);
      chk(wden, 1'b1);
      wr_gc1(16'h00a6);
      rd_reg(5'h01, rd);
      wr_reg(5'h01, 16'h0200);
      chk(wden, 1'b1);
      wr_gc1(16'h00a6);
      wr_reg(5'h01, 16'h0200);
      chk(wden, 1'b0);
      rd_reg(5'h01, rd);
      chk(rd, 16'h0200);
      repeat (LONG + 200) @(negedge clk_i);
      chk(fs, 1'b0);
      wr_reg(5'h01, 16'h0000);
      chk(wden, 1'b1);
      repeat (LONG - 100) @(negedge clk_i);
      chk(fs, 1'b0);
      repeat (200) @(negedge clk_i);
      chk(fs, 1'b1);
      $display("test unlock done");
   endtask

   task automatic t_short;
      do_reset;
      wr_gc1(16'h0024);
      repeat (SHORT - 300) @(negedge clk_i);
      chk(fs, 1'b0);
      wr_gc1(16'h0024);
      repeat (SHORT - 100) @(negedge clk_i);
      chk(fs, 1'b0);
      repeat (200) @(negedge clk_i);
      chk(fs, 1'b1);
      do_reset;
      // trigger left at its reset value
      wr_reg(5'h00, 16'h0034);
      chk({fs, watchdog_period_select}, 2'b10);
      rd_reg(5'h00, rd);
      chk(rd, 16'h0024);
      $display("test trigger done");
   endtask

   task automatic finish_test;
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      trig = 1'b0;
      do_reset;
      t_reset;
      t_fields;
      t_dly;
      t_cur;
      t_unlock;
      t_short;
      finish_test;
   end

   // about five times the expected run
   initial
   begin
      #400us;
      fails++;
      finish_test;
   end
endmodule
